// ==== design/usr_pkg.sv ====
// shared constants and types for the serial block
package usr_pkg;

  // operating modes of the serial block
  typedef enum logic [1:0] {
    USR_ASYNC,
    USR_SYNC_MASTER,
    USR_SYNC_SLAVE,
    USR_SPI_MASTER
  } usr_mode_e;

  // receive mode field codes
  localparam logic [1:0] RXM_NORMAL  = 2'h0;
  localparam logic [1:0] RXM_DOUBLE  = 2'h1;

  // samples per bit and first voting sample
  localparam logic [4:0] OS_NORMAL   = 5'h10;
  localparam logic [4:0] OS_DOUBLE   = 5'h08;
  localparam logic [4:0] VOTE_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_DOUBLE = 5'h04;
  localparam logic [4:0] VOTE_SPAN   = 5'h02;

  // frame lengths in bits
  localparam logic [3:0] DATA_BITS   = 4'h8;
  localparam logic [3:0] SPI_BITS    = 4'h8;
  localparam logic [3:0] UART_BITS   = 4'ha;

  // integer part of the baud divisor
  localparam int         BAUD_MSB    = 15;
  localparam int         BAUD_LSB    = 6;

  // reset values
  localparam logic       TXD_IDLE    = 1'b1;
  localparam logic [9:0] DIV_RST     = 10'h000;

endpackage

// ==== design/usr_serial.sv ====
// serial block: async, sync master/slave and spi master
`timescale 1ns/100ps

module usr_serial (
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // configuration
  input  wire usr_pkg::usr_mode_e mode_i,
  input  wire logic              pin_invert_enable_i,
  input  wire logic              clock_phase_select_i,
  input  wire logic              bit_order_select_i,
  input  wire logic [1:0]        receive_mode_field_i,
  input  wire logic              parity_enable_i,
  input  wire logic              parity_odd_i,
  input  wire logic [15:0]       baud_i,
  // transmit stream
  input  wire logic [7:0]        tx_data_i,
  input  wire logic              tx_valid_i,
  output logic                   tx_ready_o,
  output logic                   tx_done_o,
  // receive stream
  output logic [7:0]             rx_data_o,
  output logic                   rx_valid_o,
  output logic                   frame_error_flag_o,
  output logic                   parity_error_o,
  // pins
  input  wire logic              rxd_i,
  output logic                   txd_o,
  input  wire logic              transfer_clock_pin_i,
  output logic                   transfer_clock_pin_o,
  output logic                   transfer_clock_pin_oe_o
);
  import usr_pkg::*;

  // insert one received bit in the chosen order
  function automatic logic [7:0] ins_bit(input logic [7:0] sh, input logic b, input logic msb);
    ins_bit = msb ? {sh[6:0], b} : {b, sh[7:1]};
  endfunction

  // reverse a byte for msb-first transmit
  function automatic logic [7:0] rev8(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = d[7-i];
    end
  endfunction

  logic       async_m, sync_m, slave, spi, master, inv;
  logic       lead_shift, ds, msb_first;
  logic [4:0] os_n, vote_f;

  // mode decode
  assign async_m    = (mode_i == USR_ASYNC);
  assign sync_m     = (mode_i == USR_SYNC_MASTER);
  assign slave      = (mode_i == USR_SYNC_SLAVE);
  assign spi        = (mode_i == USR_SPI_MASTER);
  assign master     = sync_m | spi;
  assign inv        = pin_invert_enable_i;
  assign lead_shift = ~spi | clock_phase_select_i;
  assign msb_first  = spi & bit_order_select_i;
  assign ds         = (receive_mode_field_i == RXM_DOUBLE);
  assign os_n       = ds ? OS_DOUBLE : OS_NORMAL;
  assign vote_f     = ds ? VOTE_DOUBLE : VOTE_NORMAL;

  logic [9:0] div_cnt_reg;
  logic [9:0] div_val;
  logic       tick;
  logic       tx_load, tx_busy_reg, run;

  // baud divider, fraction ignored so sync rates stay exact
  assign div_val = baud_i[BAUD_MSB:BAUD_LSB];
  assign tick    = ({1'b0, div_cnt_reg} + 11'h001) >= {1'b0, div_val};

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt_reg <= DIV_RST;
    end else if (tick | (tx_load & master)) begin
      div_cnt_reg <= DIV_RST;
    end else begin
      div_cnt_reg <= div_cnt_reg + 10'h001;
    end
  end

  logic xs1_reg, xs2_reg, xs3_reg;
  logic s_rise, s_fall;

  // slave clock synchroniser; xs2 and xs3 feed the edge detector
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      xs1_reg <= 1'b0;
      xs2_reg <= 1'b0;
      xs3_reg <= 1'b0;
    end else begin
      xs1_reg <= transfer_clock_pin_i;
      xs2_reg <= xs1_reg;
      xs3_reg <= xs2_reg;
    end
  end

  // edges seen after undoing the pin inversion
  assign s_rise = (xs2_reg ^ inv) & ~(xs3_reg ^ inv);
  assign s_fall = ~(xs2_reg ^ inv) & (xs3_reg ^ inv);

  logic xck_int_reg, xck_pin_reg, xck_oe_reg, xck_next;
  logic lead, trail;

  // master clock toggles once per divider tick, idle low internally
  assign run      = master & tx_busy_reg;
  assign xck_next = run ? (xck_int_reg ^ tick) : 1'b0;
  assign lead     = master ? (tick & run & ~xck_int_reg) : (slave & s_rise);
  assign trail    = master ? (tick & run & xck_int_reg) : (slave & s_fall);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      xck_int_reg <= 1'b0;
      xck_pin_reg <= 1'b0;
      xck_oe_reg  <= 1'b0;
    end else begin
      xck_int_reg <= xck_next;
      xck_pin_reg <= xck_next ^ inv;
      xck_oe_reg  <= master;
    end
  end

  logic        tx_ready_reg, txd_reg, tx_done_reg;
  logic [10:0] tx_sr_reg, tx_frame;
  logic [3:0]  tx_cnt_reg, tx_n;
  logic [4:0]  tx_os_reg;
  logic        present_now, a_ev, period_end, tx_last, shift_ev, done_ev;
  logic        tx_par;

  // frame build: spi has bare data, uart adds start/parity/stop
  assign tx_par   = ^tx_data_i ^ parity_odd_i;
  assign tx_n     = spi ? SPI_BITS : (UART_BITS + {3'h0, parity_enable_i});
  assign tx_frame = spi ? {3'b111, msb_first ? rev8(tx_data_i) : tx_data_i} :
                    {1'b1, parity_enable_i ? tx_par : 1'b1, tx_data_i, 1'b0};
  assign tx_load  = tx_valid_i & tx_ready_reg;

  // bit-period events; phase 0 spi presents first bit before clock
  assign present_now = async_m | (spi & ~clock_phase_select_i);
  assign a_ev        = async_m & tick & (tx_os_reg == os_n - 5'h01);
  assign period_end  = tx_busy_reg & (async_m ? a_ev : trail);
  assign tx_last     = (tx_cnt_reg == tx_n - 4'h1);
  assign shift_ev    = tx_busy_reg & ((lead_shift & ~async_m) ? lead : (period_end & ~tx_last));
  assign done_ev     = period_end & tx_last;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tx_busy_reg  <= 1'b0;
      tx_ready_reg <= 1'b1;
      txd_reg      <= TXD_IDLE;
      tx_sr_reg    <= 11'h7ff;
      tx_cnt_reg   <= 4'h0;
      tx_done_reg  <= 1'b0;
    end else begin
      tx_done_reg <= done_ev;
      if (tx_load) begin
        tx_busy_reg  <= 1'b1;
        tx_ready_reg <= 1'b0;
        tx_cnt_reg   <= 4'h0;
        if (present_now) begin
          txd_reg   <= tx_frame[0];
          tx_sr_reg <= {1'b1, tx_frame[10:1]};
        end else begin
          tx_sr_reg <= tx_frame;
        end
      end else begin
        if (shift_ev) begin
          txd_reg   <= tx_sr_reg[0];
          tx_sr_reg <= {1'b1, tx_sr_reg[10:1]};
        end
        if (period_end) begin
          tx_cnt_reg <= tx_cnt_reg + 4'h1;
        end
        // phase 1 spi samples its last bit on this very edge, so the bit must stay
        if (done_ev) begin
          tx_busy_reg  <= 1'b0;
          tx_ready_reg <= 1'b1;
          if (~spi | ~clock_phase_select_i) begin
            txd_reg <= TXD_IDLE;
          end
        end
        // async and sync master lines idle high whatever an spi frame left behind
        if (~tx_busy_reg & (async_m | sync_m)) begin
          txd_reg <= TXD_IDLE;
        end
      end
    end
  end

  // async transmit sample counter, same rate as receiver
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tx_os_reg <= 5'h00;
    end else if (tx_load | ~tx_busy_reg) begin
      tx_os_reg <= 5'h00;
    end else if (tick & async_m) begin
      tx_os_reg <= a_ev ? 5'h00 : tx_os_reg + 5'h01;
    end
  end

  logic       os_busy_reg, os_prev_reg;
  logic [4:0] os_cnt_reg, os_cnt_next;
  logic [1:0] vote_reg;
  logic       maj, a_bit_ev, s_bit_ev, rx_ev, rx_val, rx_last;
  logic       rx_active_reg;
  logic [3:0] rx_cnt_reg;

  // oversampler: sample index wraps 1..os_n inside each bit
  assign os_cnt_next = (os_cnt_reg == os_n) ? 5'h01 : os_cnt_reg + 5'h01;
  assign maj = (vote_reg[1] & vote_reg[0]) | (vote_reg[1] & rxd_i) | (vote_reg[0] & rxd_i);
  assign a_bit_ev = async_m & tick & os_busy_reg & (os_cnt_next == vote_f + VOTE_SPAN);
  assign rx_last  = rx_active_reg & ~spi & (rx_cnt_reg == DATA_BITS + {3'h0, parity_enable_i});

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      os_busy_reg <= 1'b0;
      os_prev_reg <= 1'b1;
      os_cnt_reg  <= 5'h00;
      vote_reg    <= 2'h3;
    end else if (~async_m) begin
      os_busy_reg <= 1'b0;
    end else if (tick) begin
      os_prev_reg <= rxd_i;
      vote_reg    <= {vote_reg[0], rxd_i};
      if (~os_busy_reg) begin
        if (os_prev_reg & ~rxd_i) begin
          os_busy_reg <= 1'b1;
          os_cnt_reg  <= 5'h01;
        end
      end else begin
        os_cnt_reg <= os_cnt_next;
        if (a_bit_ev & ((~rx_active_reg & maj) | rx_last)) begin
          os_busy_reg <= 1'b0;
        end
      end
    end
  end

  // sync receive samples on the edge that does not shift
  assign s_bit_ev = ~async_m & (lead_shift ? trail : lead) & (~spi | tx_busy_reg);
  assign rx_ev    = async_m ? a_bit_ev : s_bit_ev;
  assign rx_val   = async_m ? maj : rxd_i;

  logic [7:0] rx_sh_reg, rx_data_reg, rx_ins;
  logic       rx_valid_reg, frame_error_flag_reg, perr_reg, rx_par_reg, perr_hold_reg;

  assign rx_ins = ins_bit(rx_sh_reg, rx_val, msb_first);

  // frame assembler shared by all modes
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rx_active_reg <= 1'b0;
      rx_cnt_reg    <= 4'h0;
      rx_sh_reg     <= 8'h00;
      rx_data_reg   <= 8'h00;
      rx_valid_reg  <= 1'b0;
      frame_error_flag_reg      <= 1'b0;
      perr_reg      <= 1'b0;
      rx_par_reg    <= 1'b0;
      perr_hold_reg <= 1'b0;
    end else begin
      rx_valid_reg <= 1'b0;
      if (rx_ev) begin
        if (~rx_active_reg) begin
          if (spi) begin
            rx_active_reg <= 1'b1;
            rx_cnt_reg    <= 4'h1;
            rx_sh_reg     <= rx_ins;
          end else if (~rx_val) begin
            rx_active_reg <= 1'b1;
            rx_cnt_reg    <= 4'h0;
            rx_par_reg    <= parity_odd_i;
            perr_hold_reg <= 1'b0;
          end
        end else if (rx_cnt_reg < DATA_BITS) begin
          rx_sh_reg  <= rx_ins;
          rx_cnt_reg <= rx_cnt_reg + 4'h1;
          rx_par_reg <= rx_par_reg ^ rx_val;
          if (spi & (rx_cnt_reg == SPI_BITS - 4'h1)) begin
            rx_active_reg <= 1'b0;
            rx_data_reg   <= rx_ins;
            rx_valid_reg  <= 1'b1;
            frame_error_flag_reg      <= 1'b0;
            perr_reg      <= 1'b0;
          end
        end else if (~rx_last) begin
          perr_hold_reg <= rx_par_reg ^ rx_val;
          rx_cnt_reg    <= rx_cnt_reg + 4'h1;
        end else begin
          rx_active_reg <= 1'b0;
          rx_data_reg   <= rx_sh_reg;
          rx_valid_reg  <= 1'b1;
          frame_error_flag_reg      <= ~rx_val;
          perr_reg      <= perr_hold_reg;
        end
      end
    end
  end

  // outputs straight from flip-flops
  assign tx_ready_o              = tx_ready_reg;
  assign tx_done_o               = tx_done_reg;
  assign txd_o                   = txd_reg;
  assign rx_data_o               = rx_data_reg;
  assign rx_valid_o              = rx_valid_reg;
  assign frame_error_flag_o      = frame_error_flag_reg;
  assign parity_error_o          = perr_reg;
  assign transfer_clock_pin_o    = xck_pin_reg;
  assign transfer_clock_pin_oe_o = xck_oe_reg;

  // helper: leads counted per transmit frame
  logic [3:0] lead_cnt_reg;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      lead_cnt_reg <= 4'h0;
    end else if (tx_load) begin
      lead_cnt_reg <= 4'h0;
    end else if (lead & tx_busy_reg) begin
      lead_cnt_reg <= lead_cnt_reg + 4'h1;
    end
  end

  a_oe_role: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ##1 transfer_clock_pin_oe_o == $past(master))
    else $error("clock pin direction wrong for role");

  a_pin_idle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ~run ##1 $stable(inv) |-> transfer_clock_pin_o == inv)
    else $error("idle clock pin level wrong");

  a_spi_eight: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    done_ev & spi |-> lead_cnt_reg == 4'h8)
    else $error("spi frame not eight clocks");

  a_spi_err_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rx_ev & spi & $stable(mode_i) |=> ~rx_valid_o | (~frame_error_flag_o & ~parity_error_o))
    else $error("spi error flags not zero");

  a_start_reject: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    a_bit_ev & ~rx_active_reg & maj |=> ~os_busy_reg & ~rx_active_reg)
    else $error("false start bit not rejected");

  a_stop_frame_error_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rx_ev & rx_last & ~rx_val |=> rx_valid_o & frame_error_flag_o)
    else $error("low stop bit missed frame error");

  a_slave_no_baud: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    slave & ~tx_load & ~s_rise & ~s_fall |=> $stable(txd_o))
    else $error("slave data moved without clock edge");

  a_master_half: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    master & run & ~tick & $stable(inv) ##1 $stable(inv) |-> $stable(transfer_clock_pin_o))
    else $error("master clock moved off divider tick");

  a_bit_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    spi & tx_busy_reg & ~tx_load & ~lead & ~trail |=> $stable(txd_o))
    else $error("spi data changed inside clock period");

endmodule

// ==== tb/usr_peer.sv ====
// serial peer model: async sender and external transfer clock source
`timescale 1ns/100ps
module usr_peer (
  // clock
  input  wire logic clk_sys_i,
  // pins toward the block
  input  wire logic txd_i,
  output logic      rxd_o,
  output logic      xck_o
);
  logic [9:0] cap_reg;

  // line idles high, clock stands still outside frames
  initial begin
    rxd_o = 1'b1;
    xck_o = 1'b0;
    cap_reg = 10'h000;
  end

  // start, data lsb first, stop held for stop_len clocks, then idle gap
  task automatic uart_send(input logic [7:0] d, input int spb, input logic stop_lvl,
                           input int stop_len, input int gap);
    logic [8:0] f;
    f = {d, 1'b0};
    for (int i = 0; i < 9; i++) begin
      @(negedge clk_sys_i) rxd_o = f[i];
      repeat (spb - 1) @(negedge clk_sys_i);
    end
    @(negedge clk_sys_i) rxd_o = stop_lvl;
    repeat (stop_len - 1) @(negedge clk_sys_i);
    @(negedge clk_sys_i) rxd_o = 1'b1;
    repeat (gap) @(negedge clk_sys_i);
  endtask

  // short low glitch, too short to pass the start vote
  task automatic pulse_low(input int n);
    @(negedge clk_sys_i) rxd_o = 1'b0;
    repeat (n) @(negedge clk_sys_i);
    rxd_o = 1'b1;
  endtask

  // half period of six clocks keeps the rate well under a quarter
  task automatic ext_clock(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (6) @(negedge clk_sys_i);
      xck_o = 1'b1;
      repeat (6) @(negedge clk_sys_i);
      cap_reg = {txd_i, cap_reg[9:1]}; // sampled just before the falling edge
      xck_o = 1'b0;
    end
  endtask
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the serial block
`timescale 1ns/100ps
module tb_top;
  import usr_pkg::*;

  typedef struct {
    logic [1:0] rxm;
    logic [7:0] d;
    logic       stop;
    int         slen;
    int         gap;
  } usr_tb_row_s;

  logic        clk, rst, inv, cpha, order, tx_valid, loop_sel, par_en;
  logic        tx_ready, tx_done, rx_valid, frame_error_flag, perr, txd, pin_o, pin_oe, peer_rxd, peer_xck, pin_prev;
  logic [1:0]  rxm;
  logic [7:0]  tx_data, rx_data, spi_cap;
  logic [15:0] baud;
  logic [9:0]  frame;
  usr_mode_e   mode;
  int          n_errors, tests_run, n_edge, n_done;
  logic [9:0]  rxq[$];

  // tight stops exercise the earliest legal next start
  usr_tb_row_s rows [7] = '{'{2'h0, 8'ha5, 1'b1, 11, 0}, '{2'h0, 8'h00, 1'b1, 11, 0},
                            '{2'h2, 8'hff, 1'b1, 11, 0}, '{2'h3, 8'h3c, 1'b1, 16, 4},
                            '{2'h1, 8'h5a, 1'b1, 7, 0}, '{2'h1, 8'h81, 1'b0, 8, 8},
                            '{2'h0, 8'h7e, 1'b0, 16, 16}};

  usr_serial dut (
    .clk_sys_i(clk), .rst_i(rst), .mode_i(mode), .pin_invert_enable_i(inv),
    .clock_phase_select_i(cpha), .bit_order_select_i(order), .receive_mode_field_i(rxm),
    .parity_enable_i(par_en), .parity_odd_i(1'b0), .baud_i(baud), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .tx_done_o(tx_done), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .frame_error_flag_o(frame_error_flag), .parity_error_o(perr),
    .rxd_i(loop_sel ? txd : peer_rxd), .txd_o(txd), .transfer_clock_pin_i(peer_xck),
    .transfer_clock_pin_o(pin_o), .transfer_clock_pin_oe_o(pin_oe)
  );

  usr_peer peer (.clk_sys_i(clk), .txd_i(txd), .rxd_o(peer_rxd), .xck_o(peer_xck));

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  // mid-cycle monitor: frames, done pulses, pin edges, spi sample capture
  always @(negedge clk) begin
    if (rx_valid === 1'b1) rxq.push_back({perr, frame_error_flag, rx_data});
    if (tx_done === 1'b1) n_done++;
    if (pin_o !== pin_prev) begin
      n_edge++;
      if (pin_o === (inv ~^ cpha)) spi_cap = {spi_cap[6:0], txd};
    end
    pin_prev = pin_o;
  end

  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic expect_rx(input logic [9:0] exp);
    logic [9:0] got;
    got = 'x;
    if (rxq.size() > 0) got = rxq.pop_front();
    check(got, exp);
  endtask

  // request held one cycle while the transmitter is free
  task automatic load(input logic [7:0] d);
    @(negedge clk);
    n_done = 0;
    tx_data = d;
    tx_valid = 1'b1;
    @(negedge clk);
    tx_valid = 1'b0;
  endtask

  task automatic wait_done(input int lim);
    int i;
    i = 0;
    while (n_done == 0 && i < lim) begin
      @(negedge clk);
      i++;
    end
    check(10'(n_done), 10'h001);
  endtask

  task automatic print_verdict();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // watchdog sized well above the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end

  initial begin
    logic [7:0] d, dr;
    clk = 1'b0; rst = 1'b1; mode = USR_ASYNC; inv = 1'b0; cpha = 1'b0; order = 1'b0;
    rxm = RXM_NORMAL; baud = 16'h0040; tx_data = 8'h00; tx_valid = 1'b0; loop_sel = 1'b0;
    pin_prev = 1'b0; spi_cap = 8'h00; frame = 10'h000; par_en = 1'b0;
    n_errors = 0; tests_run = 0; n_edge = 0; n_done = 0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check({7'h00, txd, tx_ready, pin_oe}, 10'h006);
    // receive cases including two low stop bits, all four receive mode field codes, sent back to back
    for (int r = 0; r < 7; r++) begin
      rxm = rows[r].rxm;
      peer.uart_send(rows[r].d, int'(rxm == RXM_DOUBLE ? OS_DOUBLE : OS_NORMAL), rows[r].stop,
                     rows[r].slen, rows[r].gap);
    end
    repeat (20) @(negedge clk);
    for (int r = 0; r < 7; r++) expect_rx({1'b0, ~rows[r].stop, rows[r].d});
    // glitch that ends before the vote window must not start a frame
    rxm = RXM_NORMAL;
    peer.pulse_low(4);
    repeat (40) @(negedge clk);
    check(10'(rxq.size()), 10'h000);
    // async transmit looped back into the receiver, sampled at bit centres
    loop_sel = 1'b1;
    load(8'hc3);
    for (int b = 0; b < 10; b++) begin
      repeat (b == 0 ? 8 : 16) @(negedge clk);
      frame = {txd, frame[9:1]};
    end
    wait_done(20);
    check(frame, {1'b1, 8'hc3, 1'b0});
    expect_rx({2'b00, 8'hc3});
    // parity: a looped frame passes, a wrong parity bit from the peer is flagged
    par_en = 1'b1;
    load(8'h6d);
    wait_done(200);
    repeat (20) @(negedge clk);
    expect_rx({2'b00, 8'h6d});
    loop_sel = 1'b0;
    peer.uart_send(8'h01, 16, 1'b0, 16, 20);
    expect_rx({2'b10, 8'h01});
    par_en = 1'b0;
    loop_sel = 1'b1;
    // spi master: every inversion, phase and order setting, looped back
    mode = USR_SPI_MASTER;
    baud = 16'h0080;
    for (int k = 0; k < 8; k++) begin
      {inv, cpha, order} = 3'(k);
      d = 8'h4b ^ 8'(k);
      dr = {<<{d}};
      repeat (4) @(negedge clk);
      n_edge = 0;
      load(d);
      wait_done(100);
      repeat (2) @(negedge clk);
      check(10'(n_edge), 10'h010);
      check({2'b00, spi_cap}, {2'b00, order ? d : dr});
      expect_rx({2'b00, d});
      check({8'h00, pin_oe, pin_o}, {8'h00, 1'b1, inv});
    end
    // sync slave: clock from the peer, large divisor must not slow it
    mode = USR_SYNC_SLAVE;
    {inv, cpha, order} = 3'b000;
    baud = 16'hffc0;
    loop_sel = 1'b0;
    repeat (4) @(negedge clk);
    load(8'h35);
    peer.ext_clock(10);
    wait_done(40);
    check(peer.cap_reg, {1'b1, 8'h35, 1'b0});
    check({9'h000, pin_oe}, 10'h000);
    // sync master uart looped back: receive samples on the edge that does not shift
    mode = USR_SYNC_MASTER;
    baud = 16'h0080;
    loop_sel = 1'b1;
    repeat (4) @(negedge clk);
    load(8'h96);
    wait_done(100);
    repeat (2) @(negedge clk);
    expect_rx({2'b00, 8'h96});
    check({9'h000, pin_oe}, 10'h001);
    print_verdict();
  end
endmodule
